// >>> logic/srs_pkg.sv
package srs_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_MHZ = 250;
  localparam int POR_DELAY_MS = 60;
  localparam int POR_DELAY_CYCLES = POR_DELAY_MS * CLK_MHZ * 1000;
  localparam int WARM_HOLD_CYCLES = 16;
  localparam int CNT_W = 24;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths and reset values
  localparam int GPIO_N = 9;
  localparam int SYNC_W = 3;
  localparam logic [GPIO_N-1:0] GPIO_ALL_HIZ = 9'h1ff;
  localparam logic RST_ON_N = 1'b0;
  localparam logic RST_OFF_N = 1'b1;
  localparam logic FLAG_OFF = 1'b0;
  localparam logic FLAG_ON = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // State machines
  typedef enum {
    SYS_POR_HOLD,
    SYS_PLL_SETTLE,
    SYS_WARM_HOLD,
    SYS_RUN
  } srs_sys_state_t;

  typedef enum {
    BU_HELD,
    BU_GEN_READY,
    BU_PLL_STARTING,
    BU_PLL_LOCKED,
    BU_RATES_SET,
    BU_CLOCKS_RUN,
    BU_DONE
  } srs_bu_state_t;

endpackage

// >>> logic/srs_sync.sv
`timescale 1ns/100ps
module srs_sync #(
  parameter int W = 3
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  // Two-stage synchroniser, first stage read only by the second
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta_r[g] <= 1'b0;
          o_sync[g] <= 1'b0;
        end else begin
          meta_r[g] <= i_async[g];
          o_sync[g] <= meta_r[g];
        end
      end
    end
  endgenerate

endmodule // srs_sync

// >>> logic/srs_reset_sequencer.sv
`timescale 1ns/100ps
module srs_reset_sequencer #(
  parameter int P_POR_DELAY_CYCLES = srs_pkg::POR_DELAY_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_POWER_ON_SENSE,
  input wire logic I_SUPPLY_WARNING_N,
  input wire logic I_WDOG_TIMEOUT,
  input wire logic I_DISPLAY_LINK_PLL_LOCK,
  input wire logic I_FW_GEN_PROGRAMMED,
  input wire logic I_FW_PLL_ENABLE,
  input wire logic I_FW_RATE_SET,
  input wire logic I_FW_DIV_RELEASE,
  input wire logic I_FW_EXT_RELEASE,
  input wire logic I_FW_LINK_IO_RELEASE,
  input wire logic [srs_pkg::GPIO_N-1:0] I_FW_GPIO_OE_N,
  output logic O_PRIMARY_PLL_RESET_N,
  output logic O_PRIMARY_CLKS_EN,
  output logic O_NORMAL_POWER_MODE,
  output logic O_CPU_RESET_N,
  output logic O_PERIPH_RESET_N,
  output logic O_CPU_CLK_FULL_RATE,
  output logic O_BOOT_FROM_FLASH,
  output logic O_BOOT_START,
  output logic [srs_pkg::GPIO_N-1:0] O_GPIO_OE_N,
  output logic O_DISPLAY_LINK_PLL_PWRDN,
  output logic O_LINK_DIV_RESET_N,
  output logic O_LINK_CLKS_EN,
  output logic O_LINK_PLL_LOCKED,
  output logic O_LINK_IO_PWRDN,
  output logic O_LINK_IO_OE_N,
  output logic O_LINK_IO_RESET_N,
  output logic O_EXT_RESET_N,
  output logic O_SEQ_ERROR
);
  import srs_pkg::*;

  localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(P_POR_DELAY_CYCLES - 1);
  localparam logic [CNT_W-1:0] WARM_LAST = CNT_W'(WARM_HOLD_CYCLES - 1);
  logic [SYNC_W-1:0] pin_sync;
  logic pos_s;
  logic pgood_s;
  logic lock_s;
  logic warn;
  srs_sys_state_t sys_r;
  srs_sys_state_t sys_nxt;
  srs_bu_state_t bu_r;
  srs_bu_state_t bu_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic fw_cmd_any;
  logic seq_err_nxt;
  logic io_rel_r;

  // True while the processor is out of reset
  function automatic logic sys_running(input srs_sys_state_t s);
    return (s == SYS_RUN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  srs_sync #(
    .W(SYNC_W)
  ) u_sync (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_async({I_DISPLAY_LINK_PLL_LOCK, I_SUPPLY_WARNING_N, I_POWER_ON_SENSE}),
    .o_sync(pin_sync)
  );

  assign {lock_s, pgood_s, pos_s} = pin_sync;
  assign warn = !pgood_s;

  ////////////////////////////////////////////////////////////////////////////////
  // System reset state machine
  always_comb begin
    sys_nxt = sys_r;
    if (!pos_s) begin
      sys_nxt = SYS_POR_HOLD;
    end else begin
      case (sys_r)
        SYS_POR_HOLD: sys_nxt = SYS_PLL_SETTLE;
        SYS_PLL_SETTLE: if (cnt_r == POR_LAST) sys_nxt = SYS_RUN;
        SYS_WARM_HOLD: if (!warn && cnt_r == WARM_LAST) sys_nxt = SYS_RUN;
        SYS_RUN: if (warn || I_WDOG_TIMEOUT) sys_nxt = SYS_WARM_HOLD;
        default: sys_nxt = SYS_POR_HOLD;
      endcase
    end
  end

  // State register
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sys_r <= SYS_POR_HOLD;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  // Hold-time counter, restarted on every state change and while warned in warm hold
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cnt_r <= '0;
    end else if (sys_nxt != sys_r || sys_r == SYS_RUN || sys_r == SYS_POR_HOLD ||
                 (sys_r == SYS_WARM_HOLD && warn)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Processor-domain outputs
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PRIMARY_PLL_RESET_N <= RST_ON_N;
      O_PRIMARY_CLKS_EN <= FLAG_OFF;
      O_NORMAL_POWER_MODE <= FLAG_OFF;
      O_CPU_RESET_N <= RST_ON_N;
      O_PERIPH_RESET_N <= RST_ON_N;
      O_CPU_CLK_FULL_RATE <= FLAG_ON;
      O_BOOT_FROM_FLASH <= FLAG_ON;
      O_BOOT_START <= FLAG_OFF;
    end else begin
      O_PRIMARY_PLL_RESET_N <= (sys_nxt != SYS_POR_HOLD);
      O_PRIMARY_CLKS_EN <= (sys_nxt == SYS_RUN || sys_nxt == SYS_WARM_HOLD);
      O_NORMAL_POWER_MODE <= (sys_nxt != SYS_POR_HOLD);
      O_CPU_RESET_N <= sys_running(sys_nxt);
      O_PERIPH_RESET_N <= sys_running(sys_nxt);
      O_CPU_CLK_FULL_RATE <= FLAG_ON;
      O_BOOT_FROM_FLASH <= FLAG_ON;
      O_BOOT_START <= sys_running(sys_nxt) && !sys_running(sys_r);
    end
  end

  // GPIO held tristate until the processor runs
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_GPIO_OE_N <= GPIO_ALL_HIZ;
    end else if (!sys_running(sys_nxt)) begin
      O_GPIO_OE_N <= GPIO_ALL_HIZ;
    end else begin
      O_GPIO_OE_N <= I_FW_GPIO_OE_N;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Display link bring-up state machine
  assign fw_cmd_any = I_FW_GEN_PROGRAMMED | I_FW_PLL_ENABLE | I_FW_RATE_SET |
                      I_FW_DIV_RELEASE | I_FW_EXT_RELEASE;

  always_comb begin
    bu_nxt = bu_r;
    seq_err_nxt = 1'b0;
    // Drop back on the very edge a system reset is entered, with the processor reset
    if (!sys_running(sys_r) || !sys_running(sys_nxt)) begin
      bu_nxt = BU_HELD;
    end else begin
      case (bu_r)
        BU_HELD: if (I_FW_GEN_PROGRAMMED) bu_nxt = BU_GEN_READY;
        BU_GEN_READY: if (I_FW_PLL_ENABLE) bu_nxt = BU_PLL_STARTING;
        BU_PLL_STARTING: if (lock_s) bu_nxt = BU_PLL_LOCKED;
        BU_PLL_LOCKED: begin
          if (!lock_s) begin
            bu_nxt = BU_PLL_STARTING;
          end else if (I_FW_RATE_SET) begin
            bu_nxt = BU_RATES_SET;
          end
        end
        BU_RATES_SET: begin
          if (!lock_s) begin
            bu_nxt = BU_PLL_STARTING;
          end else if (I_FW_DIV_RELEASE) begin
            bu_nxt = BU_CLOCKS_RUN;
          end
        end
        BU_CLOCKS_RUN: if (I_FW_EXT_RELEASE) bu_nxt = BU_DONE;
        BU_DONE: bu_nxt = BU_DONE;
        default: bu_nxt = BU_HELD;
      endcase
      // A command that moved nothing came out of order and is dropped
      seq_err_nxt = fw_cmd_any && (bu_nxt == bu_r);
    end
  end

  // Bring-up state register
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bu_r <= BU_HELD;
    end else begin
      bu_r <= bu_nxt;
    end
  end

  // Link clocking outputs decoded from the next bring-up state
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_DISPLAY_LINK_PLL_PWRDN <= FLAG_ON;
      O_LINK_DIV_RESET_N <= RST_ON_N;
      O_LINK_CLKS_EN <= FLAG_OFF;
      O_EXT_RESET_N <= RST_ON_N;
      O_SEQ_ERROR <= FLAG_OFF;
    end else begin
      O_DISPLAY_LINK_PLL_PWRDN <= (bu_nxt == BU_HELD || bu_nxt == BU_GEN_READY);
      O_LINK_DIV_RESET_N <= (bu_nxt == BU_CLOCKS_RUN || bu_nxt == BU_DONE);
      O_LINK_CLKS_EN <= (bu_nxt == BU_CLOCKS_RUN || bu_nxt == BU_DONE);
      O_EXT_RESET_N <= (bu_nxt == BU_DONE);
      O_SEQ_ERROR <= seq_err_nxt;
    end
  end

  // Lock is only reported the cycle after it is seen while the link PLL is powered
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_LINK_PLL_LOCKED <= FLAG_OFF;
    end else begin
      O_LINK_PLL_LOCKED <= lock_s && !O_DISPLAY_LINK_PLL_PWRDN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link I/O release, firmware decides when attached power is back
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      io_rel_r <= FLAG_OFF;
    end else if (!sys_running(sys_nxt)) begin
      io_rel_r <= FLAG_OFF;
    end else if (I_FW_LINK_IO_RELEASE) begin
      io_rel_r <= FLAG_ON;
    end
  end

  assign O_LINK_IO_RESET_N = io_rel_r;
  assign O_LINK_IO_PWRDN = !io_rel_r;
  assign O_LINK_IO_OE_N = !io_rel_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  sequence s_por_release;
    (sys_r == SYS_POR_HOLD) ##1 (sys_r == SYS_PLL_SETTLE);
  endsequence
  sequence s_rate_cmd;
    (bu_r == BU_PLL_LOCKED) && lock_s && I_FW_RATE_SET && sys_running(sys_r) &&
      sys_running(sys_nxt);
  endsequence
  property p_por_pll_reset;
    !pos_s |=> !O_PRIMARY_PLL_RESET_N && !O_CPU_RESET_N;
  endproperty
  a_por_pll_reset: assert property (p_por_pll_reset)
    else $error("primary PLL not reset on power loss");
  property p_normal_mode;
    $rose(O_CPU_RESET_N) |-> O_NORMAL_POWER_MODE && O_PRIMARY_CLKS_EN;
  endproperty
  a_normal_mode: assert property (p_normal_mode)
    else $error("processor released outside normal power mode");
  property p_gpio_hiz;
    !O_CPU_RESET_N |-> (O_GPIO_OE_N == GPIO_ALL_HIZ);
  endproperty
  a_gpio_hiz: assert property (p_gpio_hiz)
    else $error("GPIO driven during reset");
  property p_warm_keeps_pll;
    (sys_running(sys_r) && pos_s && (warn || I_WDOG_TIMEOUT))
      |=> O_PRIMARY_PLL_RESET_N && O_PRIMARY_CLKS_EN && !O_CPU_RESET_N;
  endproperty
  a_warm_keeps_pll: assert property (p_warm_keeps_pll)
    else $error("primary PLL lost on warm reset");
  property p_only_cpu_released;
    $rose(O_CPU_RESET_N) |-> O_PERIPH_RESET_N && !O_EXT_RESET_N &&
                             !O_LINK_DIV_RESET_N && !O_LINK_IO_RESET_N;
  endproperty
  a_only_cpu_released: assert property (p_only_cpu_released)
    else $error("non-processor reset released by hardware");
  property p_full_rate;
    $rose(O_CPU_RESET_N) |-> O_CPU_CLK_FULL_RATE;
  endproperty
  a_full_rate: assert property (p_full_rate)
    else $error("processor clock not at full rate");
  property p_link_pll_down;
    !O_CPU_RESET_N |=> O_DISPLAY_LINK_PLL_PWRDN && !O_LINK_CLKS_EN && !O_LINK_DIV_RESET_N;
  endproperty
  a_link_pll_down: assert property (p_link_pll_down)
    else $error("display link PLL active after reset");
  property p_link_io_down;
    !O_CPU_RESET_N |-> O_LINK_IO_PWRDN && O_LINK_IO_OE_N && !O_LINK_IO_RESET_N;
  endproperty
  a_link_io_down: assert property (p_link_io_down)
    else $error("link I/O active during reset");
  property p_ext_held;
    !O_EXT_RESET_N ##1 O_EXT_RESET_N |-> $past(I_FW_EXT_RELEASE, 1);
  endproperty
  a_ext_held: assert property (p_ext_held)
    else $error("external reset released without firmware");
  property p_boot;
    $rose(O_CPU_RESET_N) |-> O_BOOT_START && O_BOOT_FROM_FLASH ##1 !O_BOOT_START;
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot start not one pulse at release");
  property p_rate_order;
    s_rate_cmd |=> (bu_r == BU_RATES_SET) && !O_SEQ_ERROR;
  endproperty
  a_rate_order: assert property (p_rate_order)
    else $error("rate setting after lock not accepted");
  property p_early_div;
    (sys_running(sys_r) && sys_running(sys_nxt) && lock_s && bu_r == BU_PLL_LOCKED &&
     I_FW_DIV_RELEASE && !I_FW_RATE_SET) |=> O_SEQ_ERROR && !O_LINK_DIV_RESET_N;
  endproperty
  a_early_div: assert property (p_early_div)
    else $error("divider released before rates were set");
  property p_settle;
    s_por_release |-> !O_CPU_RESET_N [*8];
  endproperty
  a_settle: assert property (p_settle)
    else $error("processor released too soon after power sense");
  property p_lock_visible;
    (lock_s && !O_DISPLAY_LINK_PLL_PWRDN) |=> O_LINK_PLL_LOCKED;
  endproperty
  a_lock_visible: assert property (p_lock_visible)
    else $error("display link PLL lock not reported");
endmodule // srs_reset_sequencer

// >>> bench/srs_link_pll_model.sv
`timescale 1ns/100ps
// Behavioural display link PLL: locks a while after power-up, loses lock at once when powered down
module srs_link_pll_model #(
  parameter int LOCK_CYCLES = 6
) (
  input wire logic i_clk,
  input wire logic i_pwrdn,
  output logic o_lock
);
  int cnt_r;
  // Lock counter, cleared while powered down
  always_ff @(posedge i_clk) begin
    if (i_pwrdn) begin
      cnt_r <= 0;
      o_lock <= 1'h0;
    end else begin
      if (cnt_r < LOCK_CYCLES) cnt_r <= cnt_r + 1;
      o_lock <= (cnt_r >= LOCK_CYCLES - 1);
    end
  end
endmodule // srs_link_pll_model

// >>> bench/system_reset_sequencer_tb.sv
`timescale 1ns/100ps
module system_reset_sequencer_tb;
  import srs_pkg::*;
  localparam int P_SETTLE = 20;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic sense = 1'h0;
  logic warn_n = 1'h1;
  logic wdog = 1'h0;
  logic lock;
  logic [5:0] cmd = 6'h00;
  logic [GPIO_N-1:0] gpio_in = 9'h1ff;
  logic pll_n, clks, norm, cpu_n, per_n, full, flash, boot, pwrdn, div_n, lclk, locked;
  logic io_pd, io_oe_n, io_n, ext_n, err;
  logic [GPIO_N-1:0] gpio_oe_n;
  int miscompares = 0;
  int samples_checked = 0;

  // Clock at 250 MHz
  always #2 clk = ~clk;

  srs_link_pll_model pll_u (.i_clk(clk), .i_pwrdn(pwrdn), .o_lock(lock));

  srs_reset_sequencer #(.P_POR_DELAY_CYCLES(P_SETTLE)) dut_u (
    .I_CLK(clk), .I_RST_N(rst_n), .I_POWER_ON_SENSE(sense), .I_SUPPLY_WARNING_N(warn_n),
    .I_WDOG_TIMEOUT(wdog), .I_DISPLAY_LINK_PLL_LOCK(lock), .I_FW_GEN_PROGRAMMED(cmd[0]),
    .I_FW_PLL_ENABLE(cmd[1]), .I_FW_RATE_SET(cmd[2]), .I_FW_DIV_RELEASE(cmd[3]),
    .I_FW_EXT_RELEASE(cmd[4]), .I_FW_LINK_IO_RELEASE(cmd[5]), .I_FW_GPIO_OE_N(gpio_in),
    .O_PRIMARY_PLL_RESET_N(pll_n), .O_PRIMARY_CLKS_EN(clks), .O_NORMAL_POWER_MODE(norm),
    .O_CPU_RESET_N(cpu_n), .O_PERIPH_RESET_N(per_n), .O_CPU_CLK_FULL_RATE(full),
    .O_BOOT_FROM_FLASH(flash), .O_BOOT_START(boot), .O_GPIO_OE_N(gpio_oe_n),
    .O_DISPLAY_LINK_PLL_PWRDN(pwrdn), .O_LINK_DIV_RESET_N(div_n), .O_LINK_CLKS_EN(lclk),
    .O_LINK_PLL_LOCKED(locked), .O_LINK_IO_PWRDN(io_pd), .O_LINK_IO_OE_N(io_oe_n),
    .O_LINK_IO_RESET_N(io_n), .O_EXT_RESET_N(ext_n), .O_SEQ_ERROR(err));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Inputs move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  // One-cycle firmware command; returns just after the edge that took it
  task automatic pulse(input int k);
    tick(1);
    cmd = 6'h01 << k;
    tick(1);
    cmd = 6'h00;
  endtask

  // Bounded wait for a level; running out ends the run
  task automatic wait_bit(input string name, input int lim, ref logic sig, input logic val,
                          output int n);
    n = 0;
    while (sig !== val) begin
      if (n >= lim) begin
        miscompares++;
        $display("unexpected %s expected %h seen %h", name, val, sig);
        stop_test();
      end
      tick(1);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_por();
    int n;
    tick(2);
    chk("cpu_rst", 9'h000, cpu_n);
    chk("pll_rst", 9'h000, pll_n);
    chk("gpio", 9'h1ff, gpio_oe_n);
    chk("pll_pd", 9'h001, pwrdn);
    chk("io_rst", 9'h000, io_n);
    chk("ext_rst", 9'h000, ext_n);
    sense = 1'h1;
    wait_bit("cpu_rst", P_SETTLE + 10, cpu_n, 1'h1, n);
    chk("settle", 9'h001, n >= P_SETTLE && n <= P_SETTLE + 5);
    chk("boot", 9'h001, boot);
    chk("flash", 9'h001, flash);
    chk("pll_rst", 9'h001, pll_n);
    chk("norm", 9'h001, norm);
    chk("per_rst", 9'h001, per_n);
    chk("clks", 9'h001, clks);
    chk("full", 9'h001, full);
    chk("div_rst", 9'h000, div_n);
    chk("ext_rst", 9'h000, ext_n);
    chk("io_pd", 9'h001, io_pd);
    chk("io_oe", 9'h001, io_oe_n);
    chk("gpio", 9'h1ff, gpio_oe_n);
    tick(1);
    chk("boot", 9'h000, boot);
  endtask

  task automatic t_order_err();
    pulse(2);
    chk("seq_err", 9'h001, err);
    chk("div_rst", 9'h000, div_n);
    tick(1);
    chk("seq_err", 9'h000, err);
  endtask

  task automatic t_bringup();
    int n;
    pulse(0);
    chk("pll_pd", 9'h001, pwrdn);
    chk("locked", 9'h000, locked);
    pulse(1);
    chk("pll_pd", 9'h000, pwrdn);
    chk("div_rst", 9'h000, div_n);
    chk("lclk", 9'h000, lclk);
    pulse(2);
    chk("seq_err", 9'h001, err);
    wait_bit("locked", 20, locked, 1'h1, n);
    pulse(3);
    chk("seq_err", 9'h001, err);
    chk("div_rst", 9'h000, div_n);
    pulse(2);
    chk("seq_err", 9'h000, err);
    chk("div_rst", 9'h000, div_n);
    pulse(3);
    chk("div_rst", 9'h001, div_n);
    chk("lclk", 9'h001, lclk);
    chk("ext_rst", 9'h000, ext_n);
    pulse(4);
    chk("ext_rst", 9'h001, ext_n);
    gpio_in = 9'h0a5;
    tick(1);
    chk("gpio", 9'h0a5, gpio_oe_n);
    pulse(5);
    chk("io_rst", 9'h001, io_n);
    chk("io_pd", 9'h000, io_pd);
    chk("io_oe", 9'h000, io_oe_n);
  endtask

  task automatic t_wdog();
    int n;
    tick(1);
    wdog = 1'h1;
    tick(1);
    wdog = 1'h0;
    chk("cpu_rst", 9'h000, cpu_n);
    chk("per_rst", 9'h000, per_n);
    chk("pll_rst", 9'h001, pll_n);
    chk("clks", 9'h001, clks);
    chk("norm", 9'h001, norm);
    chk("gpio", 9'h1ff, gpio_oe_n);
    chk("pll_pd", 9'h001, pwrdn);
    chk("div_rst", 9'h000, div_n);
    chk("lclk", 9'h000, lclk);
    chk("ext_rst", 9'h000, ext_n);
    chk("io_rst", 9'h000, io_n);
    chk("io_pd", 9'h001, io_pd);
    wait_bit("cpu_rst", 40, cpu_n, 1'h1, n);
    chk("warm_hold", 9'(WARM_HOLD_CYCLES), n[8:0]);
    chk("boot", 9'h001, boot);
    chk("ext_rst", 9'h000, ext_n);
  endtask

  task automatic t_warn();
    int n;
    tick(1);
    warn_n = 1'h0;
    wait_bit("cpu_rst", 8, cpu_n, 1'h0, n);
    chk("pll_rst", 9'h001, pll_n);
    chk("norm", 9'h001, norm);
    chk("gpio", 9'h1ff, gpio_oe_n);
    tick(3);
    warn_n = 1'h1;
    wait_bit("cpu_rst", 30, cpu_n, 1'h1, n);
    chk("warm_hold", 9'h001, n >= WARM_HOLD_CYCLES && n <= WARM_HOLD_CYCLES + 6);
    chk("pll_pd", 9'h001, pwrdn);
    chk("ext_rst", 9'h000, ext_n);
  endtask

  // Power sense drops mid-run: primary PLL reset, then full settle again
  task automatic t_power_cycle();
    int n;
    tick(1);
    sense = 1'h0;
    wait_bit("pll_rst", 6, pll_n, 1'h0, n);
    chk("cpu_rst", 9'h000, cpu_n);
    chk("pll_pd", 9'h001, pwrdn);
    chk("gpio", 9'h1ff, gpio_oe_n);
    sense = 1'h1;
    wait_bit("pll_rst", 6, pll_n, 1'h1, n);
    wait_bit("cpu_rst", P_SETTLE + 10, cpu_n, 1'h1, n);
    chk("settle", 9'h001, n >= P_SETTLE - 2 && n <= P_SETTLE + 2);
    chk("norm", 9'h001, norm);
    chk("ext_rst", 9'h000, ext_n);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence, reset held for 4 cycles
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'h1;
    t_por();
    t_order_err();
    t_bringup();
    t_wdog();
    t_warn();
    t_power_cycle();
    stop_test();
  end

  // Overall limit against a hang
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule // system_reset_sequencer_tb
